// *** verilog/external_bus_hold_grant.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Setting the hold-mode bit during a grant withdraws the acknowledge and re-drives the pins.
// - System reset clears the hold-mode bit.
// - A request held low through reset leaves the pins floated and the acknowledge low.
// - Internal code keeps running while the bus is granted away.
// - A processor access to the external interface stalls until the request is removed.
// - A grant floats address, data, both write strobes, read strobe, direction and zones 0, 6, 7.
// - Pins outside that group keep their normal function during the hold sequence.
// - Pending external accesses finish before the bus is floated.
// - The request is sampled on the rising edge of the timing clock.
// - At full rate the pins float within four timing periods plus 30 ns of the request falling.
// - At full rate the acknowledge falls within five timing periods plus 30 ns.
// - At full rate the acknowledge rises within three periods plus 30 ns, bus valid within four.
// - At half rate transitions align to rising edges of the external clock output.
module external_bus_hold_grant
	import hold_grant_pkg::*;
(
	// clock and system reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// software controls
	input wire logic hold_mode_wr_i,
	input wire logic hold_mode_wdata_i,
	input wire logic half_rate_i,
	output logic hold_mode_o,
	// processor access port
	input wire logic cpu_req_i,
	input wire logic cpu_we_i,
	input wire logic [1:0] cpu_zone_i,
	input wire logic [ADDR_W-1:0] cpu_addr_i,
	input wire logic [DATA_W-1:0] cpu_wdata_i,
	output logic cpu_stall_o,
	output logic cpu_done_o,
	output logic [DATA_W-1:0] cpu_rdata_o,
	// hold handshake pins
	input wire logic bus_request_n_i,
	output logic bus_grant_ack_n_o,
	output logic external_clock_out_o,
	// external bus pins
	output logic [ADDR_W-1:0] ext_address_bus_o,
	output logic ext_address_bus_oe_o,
	input wire logic [DATA_W-1:0] ext_data_bus_i,
	output logic [DATA_W-1:0] ext_data_bus_o,
	output logic ext_data_bus_oe_o,
	output logic write_strobe_low_n_o,
	output logic write_strobe_high_n_o,
	output logic read_strobe_n_o,
	output logic read_not_write_o,
	output logic zone_select_0_n_o,
	output logic zone_select_6_n_o,
	output logic zone_select_7_n_o,
	output logic strobe_oe_o
);
	// ****************************************
	// request synchroniser
	// ****************************************
	logic req_s1_q;
	logic req_s2_q;
	logic req_low;

	// two flops on the pin, no reset so the level is seen during reset
	always_ff @(posedge clock_i) begin
		req_s1_q <= bus_request_n_i;
		req_s2_q <= req_s1_q;
	end
	assign req_low = ~req_s2_q;

	// ****************************************
	// control state
	// ****************************************
	hold_state_e state_q, state_d;
	logic hold_mode_q, hold_mode_d;
	logic div_q, div_d;
	logic tick;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic [DATA_W-1:0] wdata_q, wdata_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic we_q, we_d;
	logic [1:0] zone_q, zone_d;
	logic done_q, done_d;

	// half rate: moves only where the clock output is about to rise
	assign tick = ~half_rate_i | ~div_q;

	// next values of sequencer and captured access
	always_comb begin
		state_d = state_q;
		hold_mode_d = hold_mode_q;
		div_d = half_rate_i ? ~div_q : DIV_RST;
		addr_d = addr_q;
		wdata_d = wdata_q;
		rdata_d = rdata_q;
		we_d = we_q;
		zone_d = zone_q;
		done_d = 1'h0;
		if (hold_mode_wr_i) begin
			hold_mode_d = hold_mode_wdata_i;
		end
		if (tick) begin
			case (state_q)
				ST_IDLE: begin
					if (req_low && !hold_mode_q) begin
						state_d = ST_FLOAT;
					end else if (cpu_req_i && !done_q) begin // done cycle closes the last request
						state_d = ST_LEAD;
						addr_d = cpu_addr_i;
						wdata_d = cpu_wdata_i;
						we_d = cpu_we_i;
						zone_d = cpu_zone_i;
					end
				end
				ST_LEAD: state_d = ST_ACTIVE;
				ST_ACTIVE: begin
					state_d = ST_TRAIL;
					rdata_d = ext_data_bus_i;
				end
				ST_TRAIL: begin
					state_d = ST_IDLE;
					done_d = 1'h1;
				end
				ST_FLOAT: state_d = ST_GRANT;
				ST_GRANT: begin
					if (!req_low || hold_mode_q) begin
						state_d = ST_RELEASE;
					end
				end
				ST_RELEASE: state_d = ST_IDLE;
				default: state_d = ST_IDLE;
			endcase
		end
		if (!resetn_i) begin
			hold_mode_d = HOLD_MODE_RST;
			div_d = DIV_RST;
			done_d = 1'h0;
			state_d = req_low ? ST_GRANT : ST_IDLE;
		end
	end

	// register the control state
	always_ff @(posedge clock_i) begin
		state_q <= state_d;
		hold_mode_q <= hold_mode_d;
		div_q <= div_d;
		addr_q <= addr_d;
		wdata_q <= wdata_d;
		rdata_q <= rdata_d;
		we_q <= we_d;
		zone_q <= zone_d;
		done_q <= done_d;
	end

	// ****************************************
	// pin drive
	// ****************************************
	logic floated;
	logic in_access;

	assign floated = (state_q == ST_FLOAT) || (state_q == ST_GRANT);
	assign in_access = (state_q == ST_LEAD) || (state_q == ST_ACTIVE);

	// floated group shares the one float term (data enable also needs a write access); other pins keep working
	assign ext_address_bus_oe_o = ~floated;
	assign strobe_oe_o = ~floated;
	assign ext_data_bus_oe_o = ~floated & in_access & we_q;
	assign ext_address_bus_o = addr_q;
	assign ext_data_bus_o = wdata_q;
	assign read_not_write_o = ~(in_access & we_q);
	assign write_strobe_low_n_o = ~((state_q == ST_ACTIVE) & we_q);
	assign write_strobe_high_n_o = ~((state_q == ST_ACTIVE) & we_q);
	assign read_strobe_n_o = ~((state_q == ST_ACTIVE) & ~we_q);
	assign zone_select_0_n_o = ~(in_access & (zone_q == ZONE_0));
	assign zone_select_6_n_o = ~(in_access & (zone_q == ZONE_6));
	assign zone_select_7_n_o = ~(in_access & (zone_q == ZONE_7));
	assign bus_grant_ack_n_o = ~(state_q == ST_GRANT);
	assign external_clock_out_o = half_rate_i ? div_q : clock_i;
	assign hold_mode_o = hold_mode_q;

	// processor side: stalled only when it touches the interface
	assign cpu_stall_o = cpu_req_i & ~done_q;
	assign cpu_done_o = done_q;
	assign cpu_rdata_o = rdata_q;

	// ****************************************
	// assertions
	// ****************************************
	localparam int HIZ_CYC = HIZ_MAX_CYC;
	localparam int ACK_CYC = ACK_MAX_CYC;
	localparam int REL_CYC = REL_MAX_CYC;
	localparam int VAL_CYC = VALID_MAX_CYC;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);

	a_reset_clears_mode: assert property (disable iff (1'h0) !resetn_i |=> !hold_mode_q)
		else $error("hold mode not cleared by reset");
	a_reset_hold_grant: assert property (disable iff (1'h0)
		(!resetn_i && !req_s2_q) |=> (!bus_grant_ack_n_o && !ext_address_bus_oe_o))
		else $error("request low in reset did not float and grant");
	a_float_in_time: assert property (!half_rate_i && !hold_mode_q && $fell(bus_request_n_i)
		&& state_q == ST_IDLE && !cpu_req_i |-> ##[1:HIZ_CYC] !ext_address_bus_oe_o)
		else $error("bus not floated in time");
	a_ack_in_time: assert property (!half_rate_i && !hold_mode_q && $fell(bus_request_n_i)
		&& state_q == ST_IDLE && !cpu_req_i |-> ##[1:ACK_CYC] !bus_grant_ack_n_o)
		else $error("grant not acknowledged in time");
	a_release_in_time: assert property (!half_rate_i && state_q == ST_GRANT
		&& $rose(bus_request_n_i) |-> ##[1:REL_CYC] bus_grant_ack_n_o)
		else $error("acknowledge not released in time");
	a_bus_valid_time: assert property (!half_rate_i && state_q == ST_GRANT
		&& $rose(bus_request_n_i) |-> ##[1:VAL_CYC] ext_address_bus_oe_o)
		else $error("bus not valid again in time");
	a_mode_withdraws: assert property ((state_q == ST_GRANT && hold_mode_q && tick)
		|=> bus_grant_ack_n_o ##1 ext_address_bus_oe_o)
		else $error("hold mode did not withdraw grant");
	a_ack_after_float: assert property (!bus_grant_ack_n_o |-> !strobe_oe_o)
		else $error("acknowledge low while pins driven");
	a_access_completes: assert property (state_q == ST_LEAD |=>
		(state_q == ST_ACTIVE || state_q == ST_LEAD) ##[1:4] done_q)
		else $error("pending access not completed before float");
	a_stall_in_grant: assert property ((cpu_req_i && state_q == ST_GRANT) |-> cpu_stall_o)
		else $error("access not stalled during grant");
	a_half_rate_align: assert property (half_rate_i && div_q && state_q == ST_GRANT
		|=> state_q == ST_GRANT)
		else $error("transition off the clock output edge");

	c_grant_seen: cover property ($fell(bus_grant_ack_n_o));
	c_withdraw: cover property (state_q == ST_GRANT && hold_mode_q);
	c_access_then_grant: cover property (state_q == ST_TRAIL ##1 state_q == ST_IDLE
		##1 state_q == ST_FLOAT);
	c_half_rate_grant: cover property (half_rate_i && $fell(bus_grant_ack_n_o));
endmodule

// *** shared/hold_grant_pkg.sv ***
package hold_grant_pkg;
	// ****************************************
	// pin widths
	// ****************************************
	localparam int ADDR_W = 20;
	localparam int DATA_W = 32;

	// ****************************************
	// zone codes on the processor side
	// ****************************************
	localparam logic [1:0] ZONE_0 = 2'h0;
	localparam logic [1:0] ZONE_6 = 2'h1;
	localparam logic [1:0] ZONE_7 = 2'h2;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic HOLD_MODE_RST = 1'h0;
	localparam logic DIV_RST = 1'h0;

	// ****************************************
	// timing, in ns, and derived cycle counts
	// ****************************************
	localparam int TIM_PERIOD_NS = 5;
	localparam int SLACK_NS = 30;
	localparam int HIZ_MAX_NS = 4 * TIM_PERIOD_NS + SLACK_NS;
	localparam int ACK_MAX_NS = 5 * TIM_PERIOD_NS + SLACK_NS;
	localparam int REL_MAX_NS = 3 * TIM_PERIOD_NS + SLACK_NS;
	localparam int VALID_MAX_NS = 4 * TIM_PERIOD_NS + SLACK_NS;
	localparam int HIZ_MAX_CYC = HIZ_MAX_NS / TIM_PERIOD_NS;
	localparam int ACK_MAX_CYC = ACK_MAX_NS / TIM_PERIOD_NS;
	localparam int REL_MAX_CYC = REL_MAX_NS / TIM_PERIOD_NS;
	localparam int VALID_MAX_CYC = VALID_MAX_NS / TIM_PERIOD_NS;

	// ****************************************
	// states of the interface sequencer
	// ****************************************
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_LEAD,
		ST_ACTIVE,
		ST_TRAIL,
		ST_FLOAT,
		ST_GRANT,
		ST_RELEASE
	} hold_state_e;
endpackage

// *** bench/bus_master_model.sv ***
`timescale 1ns/1ps
// outside master: asks for the bus, waits for the grant, uses it, lets go
module bus_master_model (
	// clock
	input wire logic clock_i,
	// control from the bench
	input wire logic start_i,
	input wire logic [7:0] use_cycles_i,
	// hold handshake
	input wire logic bus_grant_ack_n_i,
	output logic bus_request_n_o,
	output logic granted_o
);
	int n;
	// request stays low from the ask to the end of use
	initial begin
		bus_request_n_o = 1'h1;
		granted_o = 1'h0;
		forever begin
			@(posedge clock_i);
			if (start_i) begin
				bus_request_n_o <= 1'h0;
				n = 0;
				do begin
					@(posedge clock_i);
					n++;
				end while (bus_grant_ack_n_i !== 1'h0 && n < 40);
				granted_o <= (bus_grant_ack_n_i === 1'h0);
				repeat (use_cycles_i) @(posedge clock_i);
				bus_request_n_o <= 1'h1;
				granted_o <= 1'h0;
			end
		end
	end
endmodule

// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
	import hold_grant_pkg::*;
	logic clock_i, resetn_i, hold_mode_wr_i, hold_mode_wdata_i, half_rate_i;
	logic cpu_req_i, cpu_we_i, start, granted, bus_request_n_i;
	logic [1:0] cpu_zone_i;
	logic [7:0] use_cycles;
	logic [ADDR_W-1:0] cpu_addr_i, ext_address_bus_o;
	logic [DATA_W-1:0] cpu_wdata_i, ext_data_bus_i, ext_data_bus_o, cpu_rdata_o;
	logic hold_mode_o, cpu_stall_o, cpu_done_o, bus_grant_ack_n_o, external_clock_out_o;
	logic ext_address_bus_oe_o, ext_data_bus_oe_o, write_strobe_low_n_o, write_strobe_high_n_o;
	logic read_strobe_n_o, read_not_write_o, strobe_oe_o;
	logic zone_select_0_n_o, zone_select_6_n_o, zone_select_7_n_o;
	int failures = 0;
	int check_count = 0;
	int n;

	external_bus_hold_grant dut (.clock_i, .resetn_i, .hold_mode_wr_i, .hold_mode_wdata_i,
		.half_rate_i, .hold_mode_o, .cpu_req_i, .cpu_we_i, .cpu_zone_i, .cpu_addr_i,
		.cpu_wdata_i, .cpu_stall_o, .cpu_done_o, .cpu_rdata_o, .bus_request_n_i,
		.bus_grant_ack_n_o, .external_clock_out_o, .ext_address_bus_o, .ext_address_bus_oe_o,
		.ext_data_bus_i, .ext_data_bus_o, .ext_data_bus_oe_o, .write_strobe_low_n_o,
		.write_strobe_high_n_o, .read_strobe_n_o, .read_not_write_o, .zone_select_0_n_o,
		.zone_select_6_n_o, .zone_select_7_n_o, .strobe_oe_o);
	bus_master_model master (.clock_i, .start_i(start), .use_cycles_i(use_cycles),
		.bus_grant_ack_n_i(bus_grant_ack_n_o), .bus_request_n_o(bus_request_n_i),
		.granted_o(granted));

	// 200 MHz clock
	initial begin
		clock_i = 1'h0;
		forever #2.5 clock_i = ~clock_i;
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic sel(input int s);
		case (s)
			0: return bus_grant_ack_n_o;
			1: return ext_address_bus_oe_o;
			2: return bus_request_n_i;
			4: return write_strobe_low_n_o;
			default: return cpu_done_o;
		endcase
	endfunction
	// edges until the chosen signal shows v, bounded
	task automatic wait_for(input int s, input logic v, output int cnt);
		cnt = 0;
		while (sel(s) !== v) begin
			@(posedge clock_i);
			#1;
			cnt++;
			if (cnt > 60) begin
				failures++;
				$display("BAD wait %0d exp %h seen %h", s, v, sel(s));
				report_and_stop();
			end
		end
	endtask
	task automatic ask(input int len);
		@(posedge clock_i);
		start <= 1'h1;
		use_cycles <= 8'(len);
		@(posedge clock_i);
		start <= 1'h0;
		#1;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic hold_cycle(input logic half);
		int a;
		int b;
		@(posedge clock_i);
		half_rate_i <= half;
		ask(20);
		wait_for(1, 1'h0, a);
		wait_for(0, 1'h0, b);
		chk("float delay", half ? 32'(a <= 12) : a, half ? 1 : 3);
		chk("ack delay", half ? 32'(a + b <= 14) : a + b, half ? 1 : 4);
		chk("pins floated", {ext_data_bus_oe_o, strobe_oe_o, cpu_stall_o}, 0);
		chk("clock out edge", external_clock_out_o, 1);
		@(posedge clock_i);
		#1;
		chk("master granted", {granted, bus_grant_ack_n_o}, 2'h2);
		wait_for(2, 1'h1, a);
		wait_for(0, 1'h1, a);
		wait_for(1, 1'h1, b);
		chk("ack release", half ? 32'(a <= 10) : a, half ? 1 : 3);
		chk("bus valid", half ? 32'(a + b <= 12) : a + b, half ? 1 : 3);
	endtask
	task automatic access_vs_hold;
		@(posedge clock_i);
		ext_data_bus_i <= 32'h5a3c_e187;
		cpu_we_i <= 1'h0;
		cpu_addr_i <= 20'h1_2345;
		cpu_zone_i <= ZONE_6;
		cpu_req_i <= 1'h1;
		ask(30);
		chk("read pins", {zone_select_0_n_o, zone_select_6_n_o, zone_select_7_n_o,
			read_strobe_n_o, write_strobe_low_n_o, write_strobe_high_n_o,
			read_not_write_o}, 7'h57);
		wait_for(3, 1'h1, n);
		chk("driven until done", ext_address_bus_oe_o, 1);
		chk("read data", cpu_rdata_o, 32'h5a3c_e187);
		@(posedge clock_i);
		cpu_req_i <= 1'h0;
		wait_for(0, 1'h0, n);
		@(posedge clock_i);
		cpu_we_i <= 1'h1;
		cpu_zone_i <= ZONE_7;
		cpu_addr_i <= 20'h6_789a;
		cpu_req_i <= 1'h1;
		@(posedge clock_i);
		#1;
		chk("stalled in grant", {cpu_stall_o, bus_grant_ack_n_o}, 2'h2);
		wait_for(4, 1'h0, n);
		chk("write pins", {zone_select_7_n_o, write_strobe_high_n_o, read_strobe_n_o,
			read_not_write_o, ext_data_bus_oe_o}, 5'h05);
		chk("write address", 32'(ext_address_bus_o), 32'h6_789a);
		chk("write data", ext_data_bus_o, 32'h0f1e_2d3c);
		wait_for(3, 1'h1, n);
		chk("stall until release", bus_request_n_i, 1);
		@(posedge clock_i);
		cpu_req_i <= 1'h0;
		wait_for(0, 1'h1, n);
	endtask
	task automatic withdraw_and_refuse;
		ask(40);
		wait_for(0, 1'h0, n);
		@(posedge clock_i);
		hold_mode_wr_i <= 1'h1;
		hold_mode_wdata_i <= 1'h1;
		@(posedge clock_i);
		hold_mode_wr_i <= 1'h0;
		#1;
		wait_for(0, 1'h1, n);
		chk("withdraw", n <= 1, 1);
		chk("hold bit", hold_mode_o, 1);
		wait_for(1, 1'h1, n);
		chk("pins driven again", n <= 1, 1);
		wait_for(2, 1'h1, n);
		ask(5);
		repeat (10) @(posedge clock_i);
		chk("refused", bus_grant_ack_n_o, 1);
	endtask
	// request still low from the refused ask
	task automatic reset_with_request;
		@(posedge clock_i);
		resetn_i <= 1'h0;
		repeat (6) @(posedge clock_i);
		#1;
		chk("ack in reset", bus_grant_ack_n_o, 0);
		chk("floated in reset", {ext_address_bus_oe_o, ext_data_bus_oe_o, strobe_oe_o}, 0);
		chk("hold bit cleared", hold_mode_o, HOLD_MODE_RST);
		@(posedge clock_i);
		resetn_i <= 1'h1;
		wait_for(2, 1'h1, n);
		wait_for(0, 1'h1, n);
		wait_for(1, 1'h1, n);
	endtask

	// main sequence
	initial begin
		{resetn_i, hold_mode_wr_i, hold_mode_wdata_i, half_rate_i, cpu_req_i, cpu_we_i} = '0;
		{start, use_cycles, cpu_zone_i, cpu_addr_i} = '0;
		cpu_wdata_i = 32'h0f1e_2d3c;
		ext_data_bus_i = 32'ha5a5_0ff0;
		repeat (6) @(posedge clock_i);
		resetn_i <= 1'h1;
		hold_cycle(1'h0);
		access_vs_hold();
		withdraw_and_refuse();
		reset_with_request();
		hold_cycle(1'h1);
		report_and_stop();
	end
endmodule
